// ==== rtl/sarseq_defs.vh ====
// register offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef SARSEQ_DEFS_VH
`define SARSEQ_DEFS_VH
// register byte offsets on the apb bus
`define SARSEQ_OFS_CONTROL      12'h000
`define SARSEQ_OFS_RESULT       12'h004
`define SARSEQ_OFS_PINSEL       12'h008
`define SARSEQ_OFS_STATUS       12'h00c
// control register fields
`define SARSEQ_CTL_DIV_HI       7
`define SARSEQ_CTL_DIV_LO       6
`define SARSEQ_CTL_CHS_HI       5
`define SARSEQ_CTL_CHS_LO       2
`define SARSEQ_CTL_RUN          1
`define SARSEQ_CTL_PWR          0
// status register fields
`define SARSEQ_STS_DONE         7
`define SARSEQ_STS_SLEEP        0
// reset values
`define SARSEQ_DIV_RST          2'h3
`define SARSEQ_CHS_RST          4'hf
`define SARSEQ_PINSEL_RST       8'hff
// divisor selector encodings
`define SARSEQ_DIV_16           2'h0
`define SARSEQ_DIV_8            2'h1
`define SARSEQ_DIV_4            2'h2
`define SARSEQ_DIV_INT4         2'h3
// divide ratios in instruction clocks per bit period
`define SARSEQ_RATIO_16         5'h10
`define SARSEQ_RATIO_8          5'h08
`define SARSEQ_RATIO_4          5'h04
// periods per conversion and sampling periods before the marker
`define SARSEQ_PERIODS_TOTAL    4'hd
`define SARSEQ_PERIODS_SAMPLE   4'h3
// timing figures for software guidance, in ns
`define SARSEQ_TBIT_MIN_NS      500
`define SARSEQ_TBIT_MAX_NS      50000
`define SARSEQ_CLK_PERIOD_NS    25
// reference channel code
`define SARSEQ_CHS_REF          4'hf
`endif

// ==== rtl/sarseq_clkdiv.v ====
// bit-period tick generator for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defs.vh"
module sarseq_clkdiv
(
  input  wire       pclk,      // instruction clock
  input  wire       presetn,   // async reset, active low
  input  wire       run,       // counting enabled
  input  wire       int_tick,  // internal oscillator quarter tick
  input  wire [1:0] div_sel,   // latched divisor selector
  output wire       tick       // one-cycle pulse per bit period
);
  // ==========================================================
  // divider
  reg  [4:0] cnt_ff;
  wire [4:0] ratio;
  wire       fosc_tick;
  reg  [4:0] nxt_cnt;

  // ratio per selector
  assign ratio = (div_sel == `SARSEQ_DIV_16) ? `SARSEQ_RATIO_16 :
                 (div_sel == `SARSEQ_DIV_8)  ? `SARSEQ_RATIO_8  :
                 `SARSEQ_RATIO_4;
  assign fosc_tick = (cnt_ff == ratio - 5'h01);
  // internal source ticks on its own divided strobe
  assign tick = run & ((div_sel == `SARSEQ_DIV_INT4) ? int_tick : fosc_tick);

  // next count
  always @*
  begin
    nxt_cnt = cnt_ff + 5'h01;
    if (!run || fosc_tick)
      nxt_cnt = 5'h00;
  end

  // count register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 5'h00;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule // sarseq_clkdiv
`default_nettype wire

// ==== rtl/sarseq_top.v ====
// apb-attached successive-approximation converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defs.vh"
module sarseq_top
(
  input  wire        pclk,          // instruction clock, 40 mhz
  input  wire        presetn,       // async reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output wire [31:0] prdata,        // apb read data
  output wire        pready,        // apb ready
  output wire        pslverr,       // apb error
  input  wire        sleep_enter,   // one-cycle pulse: device enters sleep
  input  wire        wake,          // one-cycle pulse: device wakes
  input  wire        int_osc_tick,  // internal oscillator divided strobe, async
  input  wire        cmp_decision,  // comparator: input above trial code
  output reg  [7:0]  trial_code,    // code to digital-to-analog side
  output reg  [3:0]  channel_mux,   // channel steering to sampler
  output reg         sample_en,     // sampler tracking input
  output reg         analog_power,  // converter analog power
  output reg  [7:0]  analog_pin_select, // pins in analog mode
  output reg         done_pulse     // one-cycle pulse on normal completion
);
  // ==========================================================
  // state codes
  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  // ==========================================================
  // registers
  reg  [1:0] div_sel_ff;
  reg  [3:0] chs_ff;
  reg        run_ff;
  reg        pwr_ff;
  reg  [7:0] result_ff;
  reg        marker_ff;       // marker bit above the result, shifted in at top
  reg        done_flag_ff;
  reg        in_sleep_ff;
  reg  [1:0] state_ff;
  reg  [3:0] per_cnt_ff;
  reg  [1:0] div_act_ff;
  reg  [2:0] osc_sync_ff;
  reg        osc_prev_ff;
  reg  [1:0] nxt_state;
  reg  [3:0] nxt_per_cnt;
  reg  [7:0] nxt_result;
  reg        nxt_marker;
  reg        nxt_run;
  reg        nxt_done_flag;
  reg  [31:0] rd_mux;

  wire       wr;
  wire       rd;
  wire       hit_ctl;
  wire       hit_res;
  wire       hit_pin;
  wire       hit_sts;
  wire       mapped;
  wire       tick;
  wire       osc_level;
  wire       int_tick;
  wire       busy;
  wire       sw_run_set;
  wire       sw_run_clr;
  wire [8:0] lead_word;
  wire [8:0] lead_bit;
  wire [8:0] shift_word;
  wire       last_per;
  wire       stop_req;
  wire       conv_end;
  wire [7:0] ctl_word;

  // ==========================================================
  // apb decode, zero-wait answers
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign hit_ctl = (paddr == `SARSEQ_OFS_CONTROL);
  assign hit_res = (paddr == `SARSEQ_OFS_RESULT);
  assign hit_pin = (paddr == `SARSEQ_OFS_PINSEL);
  assign hit_sts = (paddr == `SARSEQ_OFS_STATUS);
  assign mapped  = hit_ctl | hit_res | hit_pin | hit_sts;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rd_mux;

  assign ctl_word = {div_sel_ff, chs_ff, run_ff, pwr_ff};

  // read mux
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (rd && hit_ctl)
      rd_mux = {24'h00_0000, ctl_word};
    else if (rd && hit_res)
      rd_mux = {24'h00_0000, result_ff};
    else if (rd && hit_pin)
      rd_mux = {24'h00_0000, analog_pin_select};
    else if (rd && hit_sts)
      rd_mux = {24'h00_0000, done_flag_ff, 6'h00, in_sleep_ff};
  end

  // ==========================================================
  // internal oscillator strobe synchroniser, three stages
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_sync_ff <= 3'h0;
      osc_prev_ff <= 1'b0;
    end
    else
    begin
      osc_sync_ff <= {osc_sync_ff[1:0], int_osc_tick};
      osc_prev_ff <= osc_level;
    end
  end
  // level changes once second and third stages agree
  assign osc_level = (osc_sync_ff[2] == osc_sync_ff[1]) ? osc_sync_ff[1] : osc_prev_ff;
  assign int_tick  = osc_level & ~osc_prev_ff;

  // ==========================================================
  // bit-period divider
  assign busy = (state_ff != ST_IDLE);
  sarseq_clkdiv u_clkdiv
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (busy),
    .int_tick (int_tick),
    .div_sel  (div_act_ff),
    .tick     (tick)
  );

  // ==========================================================
  // software run control
  assign sw_run_set = wr & hit_ctl & pwdata[`SARSEQ_CTL_RUN] & ~run_ff
                    & pwdata[`SARSEQ_CTL_PWR] & pwr_ff;
  assign sw_run_clr = wr & hit_ctl & ~pwdata[`SARSEQ_CTL_RUN] & run_ff;
  // the leading one is the lowest set bit of marker and result together
  assign lead_word  = {marker_ff, result_ff};
  assign lead_bit   = lead_word & (~lead_word + 9'h001);
  assign shift_word = (lead_word & ~lead_bit) | {1'b0, lead_bit[8:1]}
                    | (lead_bit & {1'b0, {8{cmp_decision}}});
  assign last_per   = (per_cnt_ff == `SARSEQ_PERIODS_TOTAL - 4'h1);
  // sleep, software clear or power-off all stop a run without completion
  assign stop_req   = sleep_enter | (busy & sw_run_clr)
                    | (wr & hit_ctl & ~pwdata[`SARSEQ_CTL_PWR]);
  assign conv_end   = tick & (state_ff == ST_CONV) & last_per & ~stop_req;

  // sequencer next state
  always @*
  begin
    nxt_state     = state_ff;
    nxt_per_cnt   = per_cnt_ff;
    nxt_result    = result_ff;
    nxt_marker    = marker_ff;
    nxt_run       = run_ff;
    nxt_done_flag = done_flag_ff;
    if (wr && hit_sts && !pwdata[`SARSEQ_STS_DONE])
      nxt_done_flag = 1'b0;
    if (wr && hit_res)
      nxt_result = pwdata[7:0];
    case (state_ff)
      ST_IDLE:
      begin
        if (sw_run_set)
        begin
          nxt_run     = 1'b1;
          nxt_state   = ST_SAMPLE;
          nxt_per_cnt = 4'h0;
        end
      end
      ST_SAMPLE:
      begin
        // previous result held while sampling
        if (tick)
          nxt_per_cnt = per_cnt_ff + 4'h1;
        if (tick && per_cnt_ff == `SARSEQ_PERIODS_SAMPLE - 4'h1)
        begin
          nxt_result = 8'h00;
          nxt_marker = 1'b1;
          nxt_state  = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (tick)
          nxt_per_cnt = per_cnt_ff + 4'h1;
        if (tick && !last_per)
        begin
          // marker moves right, decision fills vacated slot
          nxt_marker  = shift_word[8];
          nxt_result  = shift_word[7:0];
        end
        // nine shifts push the marker out; last period ends the run
        if (conv_end)
        begin
          nxt_run       = 1'b0;
          nxt_state     = ST_IDLE;
          nxt_done_flag = 1'b1;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    // software abort keeps partial bits, no done flag
    if (busy && sw_run_clr)
    begin
      nxt_run   = 1'b0;
      nxt_state = ST_IDLE;
    end
    // sleep halts and keeps partial result
    if (sleep_enter || (wr && hit_ctl && !pwdata[`SARSEQ_CTL_PWR]))
    begin
      nxt_run   = 1'b0;
      nxt_state = ST_IDLE;
    end
  end

  // sequencer registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff     <= ST_IDLE;
      per_cnt_ff   <= 4'h0;
      result_ff    <= 8'h00;
      marker_ff    <= 1'b0;
      run_ff       <= 1'b0;
      done_flag_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      per_cnt_ff   <= nxt_per_cnt;
      result_ff    <= nxt_result;
      marker_ff    <= nxt_marker;
      run_ff       <= nxt_run;
      done_flag_ff <= nxt_done_flag;
    end
  end

  // ==========================================================
  // configuration fields, sleep and wake defaults
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_sel_ff        <= `SARSEQ_DIV_RST;
      chs_ff            <= `SARSEQ_CHS_RST;
      pwr_ff            <= 1'b0;
      analog_pin_select <= `SARSEQ_PINSEL_RST;
      in_sleep_ff       <= 1'b0;
    end
    else if (wake)
    begin
      div_sel_ff        <= `SARSEQ_DIV_RST;
      chs_ff            <= `SARSEQ_CHS_RST;
      pwr_ff            <= 1'b0;
      analog_pin_select <= `SARSEQ_PINSEL_RST;
      in_sleep_ff       <= 1'b0;
    end
    else if (sleep_enter)
    begin
      div_sel_ff  <= `SARSEQ_DIV_RST;
      chs_ff      <= `SARSEQ_CHS_RST;
      pwr_ff      <= 1'b0;
      in_sleep_ff <= 1'b1;
    end
    else
    begin
      if (wr && hit_ctl)
      begin
        div_sel_ff <= pwdata[`SARSEQ_CTL_DIV_HI:`SARSEQ_CTL_DIV_LO];
        chs_ff     <= pwdata[`SARSEQ_CTL_CHS_HI:`SARSEQ_CTL_CHS_LO];
        pwr_ff     <= pwdata[`SARSEQ_CTL_PWR];
      end
      if (wr && hit_pin)
        analog_pin_select <= pwdata[7:0];
    end
  end

  // ==========================================================
  // analog-side outputs and latched divisor and channel
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_act_ff   <= `SARSEQ_DIV_RST;
      channel_mux  <= `SARSEQ_CHS_RST;
      sample_en    <= 1'b0;
      analog_power <= 1'b0;
      trial_code   <= 8'h00;
      done_pulse   <= 1'b0;
    end
    else
    begin
      // a starting write brings its own divisor and channel
      if (sw_run_set)
        div_act_ff <= pwdata[`SARSEQ_CTL_DIV_HI:`SARSEQ_CTL_DIV_LO];
      else if (!busy)
        div_act_ff <= div_sel_ff;
      if (sw_run_set)
        channel_mux <= pwdata[`SARSEQ_CTL_CHS_HI:`SARSEQ_CTL_CHS_LO];
      else if (!busy)
        channel_mux <= chs_ff;
      analog_power <= pwr_ff;
      sample_en    <= (nxt_state == ST_SAMPLE);
      // trial code: resolved bits plus the bit under
      trial_code   <= (nxt_state == ST_CONV && !nxt_marker) ? nxt_result : 8'h00;
      done_pulse   <= conv_end;
    end
  end
endmodule // sarseq_top
`default_nettype wire

// ==== test/sarseq_checker.sv ====
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sarseq_checker
(
  input wire logic        pclk,              // clock
  input wire logic        presetn,           // reset, active low
  input wire logic        psel,              // apb select
  input wire logic        penable,           // apb enable
  input wire logic        pwrite,            // apb direction
  input wire logic [11:0] paddr,             // apb address
  input wire logic [31:0] prdata,            // apb read data
  input wire logic        pready,            // apb ready
  input wire logic        pslverr,           // apb error
  input wire logic        sleep_enter,       // sleep pulse
  input wire logic        wake,              // wake pulse
  input wire logic [3:0]  channel_mux,       // channel steering
  input wire logic        sample_en,         // sampler tracking
  input wire logic        analog_power,      // analog power
  input wire logic [7:0]  analog_pin_select, // analog pins
  input wire logic        done_pulse         // completion pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  // the four mapped word addresses
  assign mapped = (paddr == 12'h000) || (paddr == 12'h004) || (paddr == 12'h008)
                  || (paddr == 12'h00c);
  // ==========================================================
  // bus and sleep behaviour
  chk_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  chk_rd_idle: assert property (!psel |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_sleep_power: assert property (sleep_enter |-> ##2 !analog_power)
    else $error("power stays on after sleep");
  chk_sleep_stop: assert property (sleep_enter |-> ##2 !sample_en)
    else $error("sampling continues after sleep");
  chk_sleep_chan: assert property (sleep_enter && !wake |-> ##[1:2] channel_mux == 4'hf)
    else $error("channel not defaulted on sleep");
  chk_sleep_pins: assert property (sleep_enter && !(psel && pwrite) |=> $stable(analog_pin_select))
    else $error("pin select changed on sleep");
  chk_wake_dflt: assert property (wake |-> ##[1:2] analog_pin_select == 8'hff && channel_mux == 4'hf)
    else $error("wake defaults missing");
  chk_done_pulse: assert property (done_pulse |=> !done_pulse)
    else $error("completion pulse longer than one cycle");
  chk_sleep_nodone: assert property (sleep_enter |-> ##2 !done_pulse ##1 !done_pulse)
    else $error("completion after sleep");
endmodule // sarseq_checker
`default_nettype wire

// ==== test/tb_sarseq_top.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_sarseq_top;
  logic        pclk, presetn, psel, penable, pwrite, sleep_enter, wake, osc, cmp, err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  tgt, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, sample_en, analog_power, done_pulse;
  wire  [7:0]  trial_code, analog_pin_select;
  wire  [3:0]  channel_mux;
  int          fails, n_checks, ocnt;
  sarseq_top u_sarseq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_enter(sleep_enter), .wake(wake), .int_osc_tick(osc),
    .cmp_decision(cmp), .trial_code(trial_code), .channel_mux(channel_mux),
    .sample_en(sample_en), .analog_power(analog_power),
    .analog_pin_select(analog_pin_select), .done_pulse(done_pulse));
  // ==========================================================
  // clock, oscillator strobe and comparator
  initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
  // 24-cycle oscillator period keeps the bit period at 600 ns
  always @(posedge pclk) begin ocnt <= (ocnt == 11) ? 0 : ocnt + 1; if (ocnt == 11) osc <= ~osc; end
  // comparator keeps the trial bit while the trial code is not above the target
  always @(posedge pclk) cmp <= (trial_code <= tgt);
  // ==========================================================
  // helpers
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin fails++; print_verdict; end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    tmo(pready === 1'b1);
    rd = prdata[7:0]; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic int ratio(input logic [1:0] dv);
    return dv == 2'h0 ? 16 : dv == 2'h1 ? 8 : dv == 2'h2 ? 4 : 24;
  endfunction
  // ==========================================================
  // scenarios
  task automatic regs;
    apb(1'b0, `SARSEQ_OFS_CONTROL, 8'h00); `CHK("control reset", 8'hfc, rd)
    apb(1'b0, `SARSEQ_OFS_PINSEL, 8'h00); `CHK("pinsel reset", 8'hff, rd)
    `CHK("mux reset", 4'hf, channel_mux)
    `CHK("power reset", 1'b0, analog_power)
    apb(1'b0, 12'h010, 8'h00); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    apb(1'b1, `SARSEQ_OFS_RESULT, 8'h3c); apb(1'b0, `SARSEQ_OFS_RESULT, 8'h00);
    `CHK("result write", 8'h3c, rd)
    apb(1'b1, `SARSEQ_OFS_CONTROL, 8'hfe); apb(1'b0, `SARSEQ_OFS_CONTROL, 8'h00);
    `CHK("run without power", 8'hfc, rd)
    `CHK("no sampling unpowered", 1'b0, sample_en)
    apb(1'b1, `SARSEQ_OFS_PINSEL, 8'h0f);
  endtask
  // full conversion with divisor and channel rewritten mid-run
  task automatic conv(input logic [1:0] dv, nd, input logic [3:0] ch, nc, input logic [7:0] t, pv);
    int i;
    tgt = t;
    apb(1'b1, `SARSEQ_OFS_CONTROL, {dv, ch, 2'b01});
    apb(1'b1, `SARSEQ_OFS_CONTROL, {dv, ch, 2'b11});
    for (i = 0; i < 100 && sample_en !== 1'b1; i++) @(posedge pclk);
    tmo(sample_en === 1'b1);
    apb(1'b0, `SARSEQ_OFS_RESULT, 8'h00); `CHK("result while sampling", pv, rd)
    apb(1'b1, `SARSEQ_OFS_CONTROL, {nd, nc, 2'b11});
    @(negedge pclk); @(negedge pclk); `CHK("mux during run", ch, channel_mux)
    for (i = 0; i < 2000 && done_pulse !== 1'b1; i++) @(posedge pclk);
    tmo(done_pulse === 1'b1);
    `CHK("length", 1'b1, i >= 12 * ratio(dv) - 12 && i <= 13 * ratio(dv) + 8)
    apb(1'b0, `SARSEQ_OFS_RESULT, 8'h00); `CHK("result", t, rd)
    @(negedge pclk); `CHK("mux after run", nc, channel_mux)
    apb(1'b0, `SARSEQ_OFS_CONTROL, 8'h00); `CHK("run cleared", {nd, nc, 2'b01}, rd)
    apb(1'b0, `SARSEQ_OFS_STATUS, 8'h00); `CHK("done flag", 8'h80, rd)
    apb(1'b1, `SARSEQ_OFS_STATUS, 8'h00);
  endtask
  // stop a run after four bits, by software or by sleep
  task automatic abort_run(input logic slp);
    int i, k;
    tgt = 8'hc3;
    k = 0;
    apb(1'b1, `SARSEQ_OFS_CONTROL, 8'h0b);
    for (i = 0; i < 1000 && trial_code[3:0] === 4'h0; i++) @(posedge pclk);
    tmo(trial_code[3:0] !== 4'h0);
    if (slp) begin sleep_enter <= 1'b1; @(posedge pclk); sleep_enter <= 1'b0; end
    else apb(1'b1, `SARSEQ_OFS_CONTROL, 8'h09);
    for (i = 0; i < 400; i++) begin @(posedge pclk); k += (done_pulse === 1'b1); end
    `CHK("no completion", 0, k)
    apb(1'b0, `SARSEQ_OFS_RESULT, 8'h00); `CHK("partial result", 8'hc8, rd)
    apb(1'b0, `SARSEQ_OFS_CONTROL, 8'h00);
    `CHK("control after stop", slp ? 8'hfc : 8'h09, rd)
    apb(1'b0, `SARSEQ_OFS_STATUS, 8'h00); `CHK("done flag clear", 1'b0, rd[7])
    if (slp) begin
      apb(1'b0, `SARSEQ_OFS_PINSEL, 8'h00); `CHK("pins kept", 8'h0f, rd)
      @(posedge pclk); wake <= 1'b1; @(posedge pclk); wake <= 1'b0;
      apb(1'b0, `SARSEQ_OFS_PINSEL, 8'h00); `CHK("pins wake", 8'hff, rd)
      apb(1'b0, `SARSEQ_OFS_CONTROL, 8'h00); `CHK("control wake", 8'hfc, rd)
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; sleep_enter = 1'b0; wake = 1'b0; osc = 1'b0; cmp = 1'b0;
    tgt = 8'h00; ocnt = 0; fails = 0; n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs;
    conv(2'h0, 2'h2, 4'h0, 4'h1, 8'h5a, 8'h3c);
    conv(2'h1, 2'h0, 4'h1, 4'h7, 8'ha5, 8'h5a);
    conv(2'h2, 2'h3, 4'h7, 4'hf, 8'hff, 8'ha5);
    conv(2'h3, 2'h1, 4'hf, 4'h3, 8'h01, 8'hff);
    abort_run(1'b0);
    abort_run(1'b1);
    print_verdict;
  end
endmodule // tb_sarseq_top
bind sarseq_top sarseq_checker u_sarseq_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_enter(sleep_enter), .wake(wake), .channel_mux(channel_mux),
  .sample_en(sample_en), .analog_power(analog_power),
  .analog_pin_select(analog_pin_select), .done_pulse(done_pulse));
`default_nettype wire
